//--- verilog/ccd_pkg.sv
// Package for the control code distribution block: register map, field
// positions, reset values and timing counts.
// Assumes a single 250 MHz system clock and word-aligned register offsets.
`default_nettype none
package ccd_pkg;
    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int NPORT   = 8;                 // Router ports served
    localparam int PW      = 3;                 // Port index width
    localparam int TW      = 16;                // Interrupt timer width
    localparam int NUM_IRQ = 64;                // Interrupt numbers

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_CTRL        = 8'h00;
    localparam logic [7:0] REG_TIME_COUNT  = 8'h04;
    localparam logic [7:0] REG_PORT_TC_EN  = 8'h08;
    localparam logic [7:0] REG_PORT_IC_EN  = 8'h0C;
    localparam logic [7:0] REG_IRQ_RX_EN   = 8'h10;
    localparam logic [7:0] REG_ACK_RX_EN   = 8'h14;
    localparam logic [7:0] REG_IRQ_TX_EN   = 8'h18;
    localparam logic [7:0] REG_ACK_TX_EN   = 8'h1C;
    localparam logic [7:0] REG_IRQ_STATE_L = 8'h20;
    localparam logic [7:0] REG_IRQ_STATE_H = 8'h24;
    localparam logic [7:0] REG_PEND_RELOAD = 8'h28;
    localparam logic [7:0] REG_CHG_RELOAD  = 8'h2C;

    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int CTRL_TC_EN    = 0;           // Global time-code enable
    localparam int CTRL_IRQ_EN   = 1;           // Global irq distribution enable
    localparam int CTRL_FILTER   = 2;           // Time-code flag filter
    localparam int CTRL_EXT      = 3;           // Extended interrupt mode
    localparam int CTRL_CHG_EN   = 4;           // Change timers enable
    localparam int CTRL_LOW_NUM  = 5;           // Lowest number first
    localparam int CTRL_ACK_PRIO = 6;           // Ack/extended class first
    localparam int CTRL_W        = 7;

    // Time count register fields
    localparam int TC_VAL_LSB  = 0;
    localparam int TC_FLAG_LSB = 6;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST        = 7'h00;
    localparam logic [NPORT-1:0]  PORT_EN_RST     = 8'h00;
    localparam logic [TW-1:0]     PEND_RELOAD_RST = 16'h0100;
    localparam logic [TW-1:0]     CHG_RELOAD_RST  = 16'h0010;

    // Control code flag encodings
    localparam logic [1:0] FLAG_TIME = 2'b00;
    localparam logic [1:0] FLAG_IRQ  = 2'b10;

    // ---------------------------------------------------------------
    // Timing: interrupt timers count in ticks of this period
    // ---------------------------------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int TICK_NS      = 1000;
    localparam int TICK_CYC     = (TICK_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
endpackage
`default_nettype wire

//--- verilog/ccd_control_code_distribution.sv
// Control code distribution: time-code counter and forwarding, distributed
// interrupt admission, state bitmap, per-number timers and queue service.
// Assumes port receive pulses and transmit sinks run on clk_sys and that a
// transmit pulse is always taken by the port in the cycle it is driven.
//
// Functional notes
// - Every accepted time-code loads the global time counter.
// - Forward time-code only if value is old plus one mod 64, never back.
// - Global and per-port time-code enables gate reception and forwarding.
// - Filter bit either drops flags other than 00 or accepts any flags.
// - Flags of the last accepted time-code are readable in the counter register.
// - With interrupt distribution on, only flags 00 count as time-codes.
// - Mode bit picks 32-number acknowledge mode or 64-number extended mode.
// - Flags 10 mark interrupt codes; bit 5 clear gives number bits 4:0.
// - Bit 5 set means acknowledge (ack mode) or numbers 32-63 (extended).
// - Two 32-bit state words; interrupt sets a bit, acknowledge clears it.
// - Pending timer per number clears the state bit on expiry.
// - Optional change timer per number limits how fast its bit changes.
// - Distribution needs global and per-port interrupt distribution enable.
// - Interrupt codes need port irq receive enable; others ack receive enable.
// - Interrupt codes need state 0, acknowledge codes need state 1.
// - A code is rejected while its number already waits in the queue.
// - Accept only with change timers off or that number's timer expired.
// - Failing codes are dropped; passing codes are queued.
// - Two bits choose class priority and round-robin or lowest-first order.
// - Send queued code to all other ports with distribution and class tx on.
// - Setting a state bit reloads its pending timer; acknowledge stops it.
// - While a change timer runs the bit is frozen and codes are dropped.
`default_nettype none
module ccd_control_code_distribution
    import ccd_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    input  wire logic [7:0]                regAddr,
    input  wire logic [31:0]               regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [31:0]               regRdata,
    input  wire logic [NPORT-1:0]          rxValid,
    input  wire logic [NPORT-1:0][7:0]     rxCode,
    output logic      [NPORT-1:0]          txValid,
    output logic      [NPORT-1:0][7:0]     txCode
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0]              ctrl;
        logic [5:0]                     timeVal;
        logic [1:0]                     timeFlags;
        logic [NPORT-1:0]               tcEn;
        logic [NPORT-1:0]               icEn;
        logic [NPORT-1:0]               irqRxEn;
        logic [NPORT-1:0]               ackRxEn;
        logic [NPORT-1:0]               irqTxEn;
        logic [NPORT-1:0]               ackTxEn;
        logic [TW-1:0]                  pendReload;
        logic [TW-1:0]                  chgReload;
        logic [NUM_IRQ-1:0]             irqState;
        logic [NUM_IRQ-1:0]             queued;
        logic [NUM_IRQ-1:0]             queuedAck;
        logic [NUM_IRQ-1:0][PW-1:0]     queuedSrc;
        logic [NUM_IRQ-1:0][TW-1:0]     pendTmr;
        logic [NUM_IRQ-1:0][TW-1:0]     chgTmr;
        logic [5:0]                     rrNext;
        logic [7:0]                     tickCnt;
        logic [NPORT-1:0]               txValid;
        logic [NPORT-1:0][7:0]          txCode;
        logic [31:0]                    rdData;
    } ccd_state_s;

    ccd_state_s st;
    ccd_state_s next_st;

    assign regRdata = st.rdData;
    assign txValid  = st.txValid;
    assign txCode   = st.txCode;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // Ports are handled in index order within a cycle, so codes arriving
    // together see earlier ports' updates, but a later forwarded time-code overwrites an earlier one.
    always_comb begin
        logic              tick;
        logic              irqOn;
        logic              extMode;
        logic              isTime;
        logic              isAck;
        logic              irqClass;
        logic              timeSent;
        logic              found;
        logic              ok;
        logic [1:0]        fl;
        logic [5:0]        num;
        logic [5:0]        sel;
        logic [5:0]        idx;
        logic [NUM_IRQ-1:0] clsIrq;
        logic [NUM_IRQ-1:0] clsOther;
        logic [NUM_IRQ-1:0] cand;
        tick     = 1'b0;
        irqOn    = 1'b0;
        extMode  = 1'b0;
        isTime   = 1'b0;
        isAck    = 1'b0;
        irqClass = 1'b0;
        timeSent = 1'b0;
        found    = 1'b0;
        ok       = 1'b0;
        fl       = 2'b00;
        num      = 6'h00;
        sel      = 6'h00;
        idx      = 6'h00;
        clsIrq   = '0;
        clsOther = '0;
        cand     = '0;
        next_st  = st;
        next_st.txValid = '0;
        next_st.rdData  = 32'h0000_0000;

        // Register writes
        if (regWr) begin
            case (regAddr)
                REG_CTRL:        next_st.ctrl       = regWdata[CTRL_W-1:0];
                REG_TIME_COUNT:  next_st.timeVal    = regWdata[TC_VAL_LSB +: 6];
                REG_PORT_TC_EN:  next_st.tcEn       = regWdata[NPORT-1:0];
                REG_PORT_IC_EN:  next_st.icEn       = regWdata[NPORT-1:0];
                REG_IRQ_RX_EN:   next_st.irqRxEn    = regWdata[NPORT-1:0];
                REG_ACK_RX_EN:   next_st.ackRxEn    = regWdata[NPORT-1:0];
                REG_IRQ_TX_EN:   next_st.irqTxEn    = regWdata[NPORT-1:0];
                REG_ACK_TX_EN:   next_st.ackTxEn    = regWdata[NPORT-1:0];
                REG_PEND_RELOAD: next_st.pendReload = regWdata[TW-1:0];
                REG_CHG_RELOAD:  next_st.chgReload  = regWdata[TW-1:0];
                default:         next_st.ctrl       = st.ctrl;
            endcase
        end

        // Register reads, answered in the following cycle
        if (regRd) begin
            case (regAddr)
                REG_CTRL:        next_st.rdData[CTRL_W-1:0] = st.ctrl;
                REG_TIME_COUNT:  next_st.rdData[7:0] = {st.timeFlags, st.timeVal};
                REG_PORT_TC_EN:  next_st.rdData[NPORT-1:0] = st.tcEn;
                REG_PORT_IC_EN:  next_st.rdData[NPORT-1:0] = st.icEn;
                REG_IRQ_RX_EN:   next_st.rdData[NPORT-1:0] = st.irqRxEn;
                REG_ACK_RX_EN:   next_st.rdData[NPORT-1:0] = st.ackRxEn;
                REG_IRQ_TX_EN:   next_st.rdData[NPORT-1:0] = st.irqTxEn;
                REG_ACK_TX_EN:   next_st.rdData[NPORT-1:0] = st.ackTxEn;
                REG_IRQ_STATE_L: next_st.rdData = st.irqState[31:0];
                REG_IRQ_STATE_H: next_st.rdData = st.irqState[63:32];
                REG_PEND_RELOAD: next_st.rdData[TW-1:0] = st.pendReload;
                REG_CHG_RELOAD:  next_st.rdData[TW-1:0] = st.chgReload;
                default:         next_st.rdData = 32'h0000_0000;
            endcase
        end

        // Timer tick divider: one enable pulse per tick period
        if (st.tickCnt == TICK_LAST) begin
            next_st.tickCnt = 8'h00;
            tick = 1'b1;
        end else begin
            next_st.tickCnt = st.tickCnt + 8'h01;
        end

        // Timers count down on ticks; reloads below override this
        if (tick) begin
            for (int n = 0; n < NUM_IRQ; n++) begin
                // A running change timer freezes the bit, so expiry waits at one
                if (st.pendTmr[n] != '0 && !(st.pendTmr[n] == 16'h0001
                    && st.ctrl[CTRL_CHG_EN] && st.chgTmr[n] > 16'h0001)) begin
                    next_st.pendTmr[n] = st.pendTmr[n] - 16'h0001;
                    if (st.pendTmr[n] == 16'h0001) begin
                        next_st.irqState[n] = 1'b0;
                    end
                end
                if (st.chgTmr[n] != '0) begin
                    next_st.chgTmr[n] = st.chgTmr[n] - 16'h0001;
                end
            end
        end

        irqOn   = st.ctrl[CTRL_IRQ_EN];
        extMode = st.ctrl[CTRL_EXT];

        // Incoming control codes
        for (int p = 0; p < NPORT; p++) begin
            fl = rxCode[p][7:6];
            // Interrupt distribution or filter forces flags 00
            isTime = (irqOn || st.ctrl[CTRL_FILTER]) ? (fl == FLAG_TIME) : 1'b1;
            if (rxValid[p] && isTime) begin
                if (st.ctrl[CTRL_TC_EN] && st.tcEn[p]) begin
                    num = next_st.timeVal + 6'h01;                  // Wraps mod 64
                    next_st.timeVal   = rxCode[p][5:0];
                    next_st.timeFlags = fl;
                    if (rxCode[p][5:0] == num) begin
                        timeSent = 1'b1;
                        for (int q = 0; q < NPORT; q++) begin
                            if (q != p && st.tcEn[q]) begin
                                next_st.txValid[q] = 1'b1;
                                next_st.txCode[q]  = rxCode[p];
                            end
                        end
                    end
                end
            end else if (rxValid[p] && irqOn && fl == FLAG_IRQ) begin
                isAck = !extMode && rxCode[p][5];
                idx   = {extMode && rxCode[p][5], rxCode[p][4:0]};
                irqClass = !rxCode[p][5];
                ok = st.icEn[p]
                    && (irqClass ? st.irqRxEn[p] : st.ackRxEn[p])
                    && (isAck ? next_st.irqState[idx] : !next_st.irqState[idx])
                    && !next_st.queued[idx]
                    && (!st.ctrl[CTRL_CHG_EN] || next_st.chgTmr[idx] == '0);
                if (ok) begin
                    next_st.queued[idx]    = 1'b1;
                    next_st.queuedAck[idx] = isAck;
                    next_st.queuedSrc[idx] = PW'(p);
                    next_st.irqState[idx]  = !isAck;
                    next_st.pendTmr[idx]   = isAck ? '0 : st.pendReload;
                    if (st.ctrl[CTRL_CHG_EN]) begin
                        next_st.chgTmr[idx] = st.chgReload;
                    end
                end
            end
        end

        // Queue service; a time-code forward owns the outputs this cycle
        for (int n = 0; n < NUM_IRQ; n++) begin
            clsIrq[n]   = st.queued[n] && !st.queuedAck[n] && n < 32;
            clsOther[n] = st.queued[n] && !clsIrq[n];
        end
        if (st.ctrl[CTRL_ACK_PRIO]) begin
            cand = (clsOther != '0) ? clsOther : clsIrq;
        end else begin
            cand = (clsIrq != '0) ? clsIrq : clsOther;
        end
        // Round-robin starts after the last sent number
        for (int k = 0; k < NUM_IRQ; k++) begin
            num = st.ctrl[CTRL_LOW_NUM] ? 6'(k) : 6'(st.rrNext + 6'(k));
            if (!found && cand[num]) begin
                found = 1'b1;
                sel   = num;
            end
        end
        if (found && !timeSent) begin
            irqClass = !st.queuedAck[sel] && !sel[5];
            for (int q = 0; q < NPORT; q++) begin
                if (PW'(q) != st.queuedSrc[sel] && st.icEn[q]
                    && (irqClass ? st.irqTxEn[q] : st.ackTxEn[q])) begin
                    next_st.txValid[q] = 1'b1;
                    next_st.txCode[q]  = {FLAG_IRQ, !irqClass, sel[4:0]};
                end
            end
            next_st.queued[sel] = 1'b0;
            next_st.rrNext      = sel + 6'h01;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st            <= '0;
            st.ctrl       <= CTRL_RST;
            st.tcEn       <= PORT_EN_RST;
            st.icEn       <= PORT_EN_RST;
            st.irqRxEn    <= PORT_EN_RST;
            st.ackRxEn    <= PORT_EN_RST;
            st.irqTxEn    <= PORT_EN_RST;
            st.ackTxEn    <= PORT_EN_RST;
            st.pendReload <= PEND_RELOAD_RST;
            st.chgReload  <= CHG_RELOAD_RST;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

//--- dv/ccd_far_node.sv
// Far-side node model: injects control codes into router ports, records output.
// Assumes one clk_sys domain and that the bench calls send from its own thread.
`default_nettype none
module ccd_far_node
    import ccd_pkg::*;
(
    input  wire logic                  clk_sys,
    output logic      [NPORT-1:0]      rxValid,
    output logic      [NPORT-1:0][7:0] rxCode,
    input  wire logic [NPORT-1:0]      txValid,
    input  wire logic [NPORT-1:0][7:0] txCode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NPORT-1:0]      seen;
    logic [NPORT-1:0][7:0] firstTx;
    logic [NPORT-1:0][7:0] lastTx;
    initial begin
        rxValid = '0;
        rxCode  = '0;
        seen    = '0;
    end
    // Take every pulse in its own cycle: the router has no ready to wait on
    always @(posedge clk_sys) begin
        for (int q = 0; q < NPORT; q++) begin
            if (txValid[q]) begin
                if (!seen[q]) firstTx[q] <= txCode[q];
                lastTx[q] <= txCode[q];
                seen[q]   <= 1'b1;
            end
        end
    end
    // ----------------------------------------
    // One-cycle code on ports m1 (c1) and m2 (c2); codes go out as given, c1 wins on shared ports
    // ----------------------------------------
    task automatic send(input logic [NPORT-1:0] m1, input logic [7:0] c1,
                        input logic [NPORT-1:0] m2, input logic [7:0] c2);
        @(posedge clk_sys);
        seen <= '0;
        for (int p = 0; p < NPORT; p++) begin
            rxValid[p] <= m1[p] | m2[p];
            rxCode[p]  <= m1[p] ? c1 : (m2[p] ? c2 : ~rxCode[p]);
        end
        @(posedge clk_sys);
        rxValid <= '0;
        rxCode  <= ~rxCode; // Idle lines never keep the last code
    endtask
endmodule
`default_nettype wire

//--- dv/ccd_control_code_distribution_assertions.sv
// Checker for the control code block: watches top ports only.
// Assumes enables change only while no code is in flight.
`default_nettype none
module ccd_control_code_distribution_assertions
    import ccd_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rstn,
    input wire logic [7:0]            regAddr,
    input wire logic [31:0]           regWdata,
    input wire logic                  regWr,
    input wire logic                  regRd,
    input wire logic [31:0]           regRdata,
    input wire logic [NPORT-1:0]      rxValid,
    input wire logic [NPORT-1:0][7:0] rxCode,
    input wire logic [NPORT-1:0]      txValid,
    input wire logic [NPORT-1:0][7:0] txCode
);
    logic [CTRL_W-1:0] ctrl;
    logic [NPORT-1:0]  tcEn, icEn, itEn, atEn, tcTx, irqTx, ackTx, oddTx, f10Tx, badTc;
    logic [7:0]        rxAny, codeRef;
    // Shadow the register-written enables; the block itself never alters them
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl    <= CTRL_RST;
            tcEn    <= PORT_EN_RST;
            icEn    <= PORT_EN_RST;
            itEn    <= PORT_EN_RST;
            atEn    <= PORT_EN_RST;
            codeRef <= 8'h00;
        end else begin
            if (regWr && regAddr == REG_CTRL) ctrl <= regWdata[CTRL_W-1:0];
            if (regWr && regAddr == REG_PORT_TC_EN) tcEn <= regWdata[NPORT-1:0];
            if (regWr && regAddr == REG_PORT_IC_EN) icEn <= regWdata[NPORT-1:0];
            if (regWr && regAddr == REG_IRQ_TX_EN) itEn <= regWdata[NPORT-1:0];
            if (regWr && regAddr == REG_ACK_TX_EN) atEn <= regWdata[NPORT-1:0];
            codeRef <= rxAny;
        end
    end
    // Classify each output pulse by its flag and class bits
    always_comb begin
        rxAny = 8'h00;
        for (int q = 0; q < NPORT; q++) begin
            if (rxValid[q]) rxAny = rxAny | rxCode[q];
            tcTx[q]  = txValid[q] && txCode[q][7:6] == FLAG_TIME;
            f10Tx[q] = txValid[q] && txCode[q][7:6] == FLAG_IRQ;
            irqTx[q] = f10Tx[q] && !txCode[q][5];
            ackTx[q] = f10Tx[q] && txCode[q][5];
            oddTx[q] = txValid[q] && txCode[q][6];
            badTc[q] = tcTx[q] && txCode[q] != codeRef;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_TC_GLOBAL: assert property (tcTx != 0 |-> $past(ctrl[CTRL_TC_EN]))
        else $error("time-code sent while globally off");
    AST_TC_PORTS: assert property (tcTx != 0 |-> (tcTx & ~$past(tcEn)) == 0
        && ($past(rxValid) & $past(tcEn)) != 0)
        else $error("time-code crossed a disabled port");
    AST_TC_NOT_BACK: assert property ($onehot($past(rxValid)) |-> (tcTx & $past(rxValid)) == 0)
        else $error("time-code sent back to its source");
    AST_TC_CODE: assert property ($onehot($past(rxValid)) |-> badTc == 0)
        else $error("forwarded time-code differs from received one");
    AST_ODD_FLAGS: assert property (oddTx != 0 |-> !$past(ctrl[CTRL_FILTER]) && !$past(ctrl[CTRL_IRQ_EN]))
        else $error("code with flags 01 or 11 forwarded while filtered");
    AST_FLAG10: assert property (f10Tx != 0 |-> $past(ctrl[CTRL_IRQ_EN]) || !$past(ctrl[CTRL_FILTER]))
        else $error("flags 10 code forwarded with distribution off");
    AST_IRQ_TX_EN: assert property ($past(ctrl[CTRL_IRQ_EN]) && irqTx != 0 |-> (irqTx & ~$past(icEn & itEn)) == 0)
        else $error("interrupt code sent to a port without its enables");
    AST_ACK_TX_EN: assert property ($past(ctrl[CTRL_IRQ_EN]) && ackTx != 0 |-> (ackTx & ~$past(icEn & atEn)) == 0)
        else $error("ack or extended code sent to a port without its enables");
    cover property (tcTx != 0);
    cover property (irqTx != 0);
    cover property (ackTx != 0);
endmodule
bind ccd_control_code_distribution ccd_control_code_distribution_assertions ccd_control_code_distribution_assertions_inst (
    .clk_sys, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .rxValid, .rxCode, .txValid, .txCode);
`default_nettype wire

//--- dv/tb_ccd_control_code_distribution.sv
// Self-checking bench: register tasks plus far-node code injection.
// Assumes the far-node model and the bound checker are compiled alongside.
`default_nettype none
module tb_ccd_control_code_distribution
    import ccd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_sys = 1'b0;
    logic                  rstn, regWr, regRd;
    logic [7:0]            regAddr;
    logic [31:0]           regWdata, regRdata, got;
    logic [NPORT-1:0]      rxValid, txValid;
    logic [NPORT-1:0][7:0] rxCode, txCode;
    int                    bad_count = 0;
    int                    checks_done = 0;
    logic [7:0]            rAddr [6] = '{REG_CTRL, REG_TIME_COUNT, REG_IRQ_STATE_L, REG_PEND_RELOAD, REG_CHG_RELOAD, 8'h30};
    logic [31:0]           rVal  [6] = '{32'h0, 32'h0, 32'h0, {16'h0, PEND_RELOAD_RST}, {16'h0, CHG_RELOAD_RST}, 32'h0};
    always #2 clk_sys = ~clk_sys;
    ccd_control_code_distribution ccd_control_code_distribution_inst (.clk_sys(clk_sys), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rxValid(rxValid), .rxCode(rxCode), .txValid(txValid), .txCode(txCode));
    ccd_far_node ccd_far_node_inst (.clk_sys(clk_sys), .rxValid(rxValid), .rxCode(rxCode),
        .txValid(txValid), .txCode(txCode));
    // ----------------------------------------
    // Bus, compare and injection tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 got = regRdata;
    endtask
    task automatic chk(input string name, input logic [31:0] seenV, input logic [31:0] exp);
        checks_done++;
        if (seenV !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seenV);
            bad_count++;
        end
    endtask
    // Queue service takes two edges after admission, so four leaves slack
    task automatic inject(input logic [7:0] m1, input logic [7:0] c1, input logic [7:0] m2,
                          input logic [7:0] c2, input logic [7:0] expMask);
        ccd_far_node_inst.send(m1, c1, m2, c2);
        repeat (4) @(posedge clk_sys);
        #1 chk("tx ports", {24'h0, ccd_far_node_inst.seen}, {24'h0, expMask});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk("register", got, exp);
    endtask
    task automatic order(input logic [7:0] e1, input logic [7:0] e2);
        chk("first code", {24'h0, ccd_far_node_inst.firstTx[7]}, {24'h0, e1});
        chk("second code", {24'h0, ccd_far_node_inst.lastTx[7]}, {24'h0, e2});
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs about 1400 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        give_verdict();
    end
    initial begin
        {rstn, regWr, regRd, regAddr, regWdata} = '0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (rAddr[i]) rdchk(rAddr[i], rVal[i]);
        // Time-codes: ports 0-3 enabled, others not
        wr(REG_CTRL, 32'h1);
        wr(REG_PORT_TC_EN, 32'h0F);
        inject(8'h01, 8'h01, 8'h00, 8'h00, 8'h0E);
        rdchk(REG_TIME_COUNT, 32'h01);
        inject(8'h02, 8'h05, 8'h00, 8'h00, 8'h00);
        rdchk(REG_TIME_COUNT, 32'h05);
        inject(8'h20, 8'h06, 8'h00, 8'h00, 8'h00);
        inject(8'h01, 8'h46, 8'h00, 8'h00, 8'h0E);
        rdchk(REG_TIME_COUNT, 32'h46);
        wr(REG_CTRL, 32'h5);
        inject(8'h01, 8'h47, 8'h00, 8'h00, 8'h00);
        wr(REG_CTRL, 32'h3);
        inject(8'h01, 8'h47, 8'h00, 8'h00, 8'h00);
        inject(8'h01, 8'h07, 8'h00, 8'h00, 8'h0E);
        // Distributed interrupts, acknowledge mode
        wr(REG_CTRL, 32'h2);
        for (int i = 0; i < 3; i++) wr(REG_PORT_IC_EN + 8'(4 * i), 32'hFF);
        wr(REG_IRQ_TX_EN, 32'h0F);
        wr(REG_ACK_TX_EN, 32'hF0);
        inject(8'h04, 8'h85, 8'h00, 8'h00, 8'h0B);
        rdchk(REG_IRQ_STATE_L, 32'h20);
        inject(8'h01, 8'h85, 8'h00, 8'h00, 8'h00);
        inject(8'h40, 8'hA5, 8'h00, 8'h00, 8'hB0);
        rdchk(REG_IRQ_STATE_L, 32'h0);
        inject(8'h40, 8'hA5, 8'h00, 8'h00, 8'h00);
        wr(REG_IRQ_RX_EN, 32'hFE);
        inject(8'h01, 8'h81, 8'h00, 8'h00, 8'h00);
        wr(REG_IRQ_RX_EN, 32'hFF);
        wr(REG_PORT_IC_EN, 32'hFE);
        inject(8'h01, 8'h81, 8'h00, 8'h00, 8'h00);
        wr(REG_PORT_IC_EN, 32'hFF);
        // Change timer blocks the acknowledge until it runs out
        wr(REG_CHG_RELOAD, 32'h2);
        wr(REG_CTRL, 32'h12);
        inject(8'h01, 8'h89, 8'h00, 8'h00, 8'h0E);
        inject(8'h10, 8'hA9, 8'h00, 8'h00, 8'h00);
        rdchk(REG_IRQ_STATE_L, 32'h200);
        repeat (600) @(posedge clk_sys);
        inject(8'h10, 8'hA9, 8'h00, 8'h00, 8'hE0);
        // Queue service order across the schemes
        wr(REG_CTRL, 32'h2);
        wr(REG_IRQ_TX_EN, 32'hFF);
        wr(REG_ACK_TX_EN, 32'hFF);
        inject(8'h01, 8'h82, 8'h00, 8'h00, 8'hFE);
        inject(8'h01, 8'h86, 8'h02, 8'hA6, 8'hFE);
        inject(8'h01, 8'h81, 8'h02, 8'hA2, 8'hFF);
        order(8'h81, 8'hA2);
        wr(REG_CTRL, 32'h42);
        inject(8'h01, 8'h84, 8'h02, 8'hA1, 8'hFF);
        order(8'hA1, 8'h84);
        wr(REG_CTRL, 32'h22);
        inject(8'h01, 8'h87, 8'h02, 8'h83, 8'hFF);
        order(8'h83, 8'h87);
        wr(REG_CTRL, 32'h2);
        inject(8'h01, 8'h81, 8'h02, 8'h8A, 8'hFF);
        order(8'h8A, 8'h81);
        // Extended mode and pending timer expiry
        wr(REG_PEND_RELOAD, 32'h2);
        wr(REG_CTRL, 32'hA);
        inject(8'h01, 8'hA3, 8'h00, 8'h00, 8'hFE);
        rdchk(REG_IRQ_STATE_H, 32'h8);
        repeat (200) @(posedge clk_sys);
        rdchk(REG_IRQ_STATE_H, 32'h8);
        repeat (400) @(posedge clk_sys);
        rdchk(REG_IRQ_STATE_H, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
